/* design/paged_sfr_space_decoder.sv */
// paged_sfr_space_decoder: steers core direct accesses into the paged register space.
// assumes: peripherals answer periph_rdata combinationally in the cycle of a read strobe.
`timescale 1ns/10ps
module paged_sfr_space_decoder
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // core request side
    input wire sfr_space_pkg::core_req_t req,
    output logic req_ready,
    // core answer side
    output logic done,
    output logic [7:0] rdata,
    output logic bit_refused,
    output logic ram_access,
    output logic [7:0] ram_addr,
    // peripheral register side
    output sfr_space_pkg::periph_bus_t periph,
    input wire logic [7:0] periph_rdata,
    // page in use
    output logic [7:0] page
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {st_idle, st_access, st_merge} state_t;

    state_t state_q; // sequencer state
    sfr_space_pkg::core_req_t cur_q; // accepted request
    sfr_space_pkg::periph_bus_t periph_q; // peripheral strobes
    logic [7:0] page_q; // page select register
    logic [7:0] rdata_q; // answer data
    logic done_q; // answer pulse
    logic refused_q; // bit access refused
    logic ram_q; // ram access pulse
    logic [7:0] ram_addr_q; // ram address
    logic cur_hit_q; // accepted request selects a register
    logic cur_page_reg_q; // accepted request is the page register
    logic in_space; // decode: upper half
    logic hit; // decode: register selected
    logic page_f; // decode: upper page
    logic shared; // decode: shared register
    logic bit_ok; // decode: bit-addressable
    logic page_reg; // decode: page select register
    logic accept; // request taken this cycle

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    sfr_page_decode u_decode
    (
        .addr(req.addr),
        .page(page_q),
        .in_space(in_space),
        .hit(hit),
        .page_f(page_f),
        .shared(shared),
        .bit_ok(bit_ok),
        .page_reg(page_reg)
    );

    // requests are taken only when idle
    assign req_ready = state_q == st_idle;
    assign accept = req_ready && (req.rd || req.wr);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // idle -> access, bit write adds a merge step
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= st_idle;
        end
        else
        begin
            case (state_q)
                st_idle:
                begin
                    // ram and refused accesses finish at once
                    if (accept && in_space && !(req.bit_en && !bit_ok))
                    begin
                        state_q <= st_access;
                    end
                end
                st_access:
                begin
                    // bit write must write back the merged byte
                    if (cur_q.wr && cur_q.bit_en && cur_hit_q && !cur_page_reg_q)
                    begin
                        state_q <= st_merge;
                    end
                    else
                    begin
                        state_q <= st_idle;
                    end
                end
                st_merge:
                begin
                    state_q <= st_idle;
                end
                default:
                begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // latch the accepted request and its decode
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cur_q <= '0;
            cur_hit_q <= 1'b0;
            cur_page_reg_q <= 1'b0;
        end
        else if (accept)
        begin
            cur_q <= req;
            cur_hit_q <= hit;
            cur_page_reg_q <= page_reg;
        end
    end

    // ------------------------------------------------------------
    // page select register
    // ------------------------------------------------------------
    // byte write in the access cycle changes the page
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            page_q <= sfr_space_pkg::PAGE_SEL_RESET; // RULE6
        end
        else if (state_q == st_access && cur_page_reg_q && cur_q.wr)
        begin
            page_q <= cur_q.wdata; // RULE7
        end
    end

    // ------------------------------------------------------------
    // peripheral strobes
    // ------------------------------------------------------------
    // one-cycle strobes carrying page and address
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            periph_q <= '0;
        end
        else
        begin
            periph_q.rd <= 1'b0;
            periph_q.wr <= 1'b0;
            if (accept && in_space && hit && !page_reg && !(req.bit_en && !bit_ok))
            begin
                // bit accesses read first
                periph_q.rd <= req.rd || req.bit_en; // RULE2
                periph_q.wr <= req.wr && !req.bit_en; // RULE3
                periph_q.page_f <= page_f && !shared; // RULE8
                periph_q.shared <= shared; // RULE9
                periph_q.addr <= req.addr;
                periph_q.wdata <= req.wdata;
            end
            else if (state_q == st_access && cur_q.wr && cur_q.bit_en && cur_hit_q && !cur_page_reg_q)
            begin
                // write back with the single bit changed
                periph_q.wr <= 1'b1;
                periph_q.wdata <= sfr_space_pkg::put_bit(periph_rdata, cur_q.bit_idx, cur_q.bit_val); // RULE2
            end
        end
    end

    // ------------------------------------------------------------
    // answers
    // ------------------------------------------------------------
    // done, data and refusal toward the core
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
            if (accept && in_space && req.bit_en && !bit_ok)
            begin
                // no bit addressing on this column
                done_q <= 1'b1;
                refused_q <= 1'b1; // RULE3
                rdata_q <= 8'h00;
            end
            else if (state_q == st_access && !(cur_q.wr && cur_q.bit_en && cur_hit_q && !cur_page_reg_q))
            begin
                done_q <= 1'b1;
                if (cur_page_reg_q)
                begin
                    rdata_q <= page_q; // RULE5 RULE7
                end
                else if (!cur_hit_q)
                begin
                    // reserved location reads zero
                    rdata_q <= 8'h00; // RULE4
                end
                else if (cur_q.bit_en)
                begin
                    rdata_q <= {7'h00, periph_rdata[cur_q.bit_idx]}; // RULE2
                end
                else
                begin
                    rdata_q <= periph_rdata;
                end
            end
            else if (state_q == st_merge)
            begin
                done_q <= 1'b1;
            end
        end
    end

    // lower half goes to ordinary data memory
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ram_q <= 1'b0;
            ram_addr_q <= 8'h00;
        end
        else
        begin
            ram_q <= accept && !in_space; // RULE1
            if (accept && !in_space)
            begin
                ram_addr_q <= req.addr;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign done = done_q;
    assign rdata = rdata_q;
    assign bit_refused = refused_q;
    assign ram_access = ram_q;
    assign ram_addr = ram_addr_q;
    assign periph = periph_q;
    assign page = page_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // upper-half access never reaches ram
    chk_space_routing: assert property (accept && in_space |=> !ram_access) // RULE1
        else $error("upper address routed to ram");
    // bit read on column 0/8 reads the peripheral
    chk_bit_read: assert property (accept && req.bit_en && bit_ok && hit && !page_reg |=> periph.rd) // RULE2
        else $error("bit access issued no read");
    // bit write writes back one cycle after the read
    chk_bit_merge: assert property (periph.rd && cur_q.bit_en && cur_q.wr |=> periph.wr ##1 done) // RULE2
        else $error("bit write not merged");
    // bit access elsewhere is refused next cycle
    chk_bit_refuse: assert property (accept && in_space && req.bit_en && !bit_ok // RULE3
        |=> bit_refused && done && !periph.rd) else $error("bit access not refused");
    // page register never leaks to peripherals
    chk_page_local: assert property (accept && page_reg |=> !periph.rd && !periph.wr) // RULE5
        else $error("page register sent to peripherals");
    // page write takes effect, read returns it; bit accesses to it are refused instead
    chk_page_write: assert property (accept && page_reg && req.wr && !req.bit_en // RULE7
        |=> ##1 page == $past(req.wdata, 2)) else $error("page write lost");
    chk_page_read: assert property (accept && page_reg && req.rd && !req.bit_en // RULE7
        |=> ##1 done && rdata == page) else $error("page read wrong");
    // paged registers carry the page, shared ones do not
    chk_page_combine: assert property (periph.rd && !periph.shared // RULE8
        |-> periph.page_f == (page == sfr_space_pkg::PAGE_HIGH)) else $error("page not combined");
    // any strobe to a listed shared address is marked shared and never paged
    chk_shared_page: assert property ((periph.rd || periph.wr) && sfr_space_pkg::is_shared(periph.addr) // RULE9
        |-> periph.shared && !periph.page_f) else $error("shared register paged");
    // byte access completes in fixed time
    chk_byte_done: assert property (accept && in_space && !req.bit_en |-> ##2 done) // RULE4
        else $error("byte access late");

    cov_page_f_read: cover property (periph.rd && periph.page_f);
    cov_bit_write: cover property (periph.rd ##1 periph.wr);
    cov_refused: cover property (bit_refused);
    cov_ram: cover property (ram_access);

endmodule // paged_sfr_space_decoder

/* design/sfr_page_decode.sv */
// sfr_page_decode: combines address and current page into a register select.
// assumes: page value from the page select register, address from the core.
`timescale 1ns/10ps
module sfr_page_decode
(
    // request
    input wire logic [7:0] addr,
    input wire logic [7:0] page,
    // decode result
    output logic in_space,
    output logic hit,
    output logic page_f,
    output logic shared,
    output logic bit_ok,
    output logic page_reg
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // upper half of the direct space belongs to registers
    assign in_space = addr >= sfr_space_pkg::SPACE_BASE; // RULE1
    // page select register ignores the page
    assign page_reg = in_space && addr == sfr_space_pkg::PAGE_SEL_ADDR; // RULE5
    // shared registers decode on both pages
    assign shared = in_space && sfr_space_pkg::is_shared(addr); // RULE9
    // page and address together pick paged registers
    assign page_f = page == sfr_space_pkg::PAGE_HIGH; // RULE8
    // other page values reach shared registers only
    assign hit = in_space && (shared || page_f || page == sfr_space_pkg::PAGE_LOW); // RULE8
    // bit access only on columns 0 and 8
    assign bit_ok = addr[2:0] == sfr_space_pkg::BIT_COL_MASK; // RULE2 RULE3

endmodule // sfr_page_decode

/* design/sfr_space_pkg.sv */
// sfr_space_pkg: constants, types and decode helpers for the paged register space.
// assumes: one system clock, synchronous active-high reset, core issues one access at a time.
//
// Overview of operation
// RULE1 - direct accesses 0x80 to 0xFF reach registers
// RULE2 - low nibble 0x0/0x8 registers allow bit access
// RULE3 - other registers are whole-byte only
// RULE4 - unassigned addresses are reserved, result undefined
// RULE5 - page select at 0xA7 on every page
// RULE6 - page select is 8-bit RW, resets zero
// RULE7 - write sets page, read returns page
// RULE8 - page plus address selects the register
// RULE9 - shared registers same on page 0, F
package sfr_space_pkg;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [7:0] SPACE_BASE = 8'h80;     // first register address
    localparam logic [7:0] PAGE_SEL_ADDR = 8'hA7;  // page select register
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00; // page select after reset
    localparam logic [7:0] PAGE_LOW = 8'h00;       // lower page number
    localparam logic [7:0] PAGE_HIGH = 8'h0F;      // upper page number
    localparam logic [2:0] BIT_COL_MASK = 3'h0;    // addr[2:0] of bit-addressable columns
    localparam int ACCESS_CYCLES = 2;              // byte access: request to done

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // one core request
    typedef struct packed {
        logic rd;          // read
        logic wr;          // write
        logic bit_en;      // single-bit access
        logic [2:0] bit_idx; // bit number
        logic bit_val;     // bit value for bit write
        logic [7:0] addr;  // direct address
        logic [7:0] wdata; // byte write data
    } core_req_t;

    // strobe toward peripheral registers
    typedef struct packed {
        logic rd;          // read strobe
        logic wr;          // write strobe
        logic page_f;      // upper-page register selected
        logic shared;      // page-independent register selected
        logic [7:0] addr;  // register address
        logic [7:0] wdata; // write data
    } periph_bus_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // registers decoded on every page
    function automatic logic is_shared(input logic [7:0] a);
        case (a)
            8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h8E, 8'h8F,
            8'h90, 8'h98, 8'h99, 8'hA0, 8'hA7, 8'hA8, 8'hAC, 8'hB0,
            8'hB2, 8'hB3, 8'hB6, 8'hB7, 8'hB8, 8'hD0, 8'hD1, 8'hD8,
            8'hE0, 8'hE6, 8'hE7, 8'hE8, 8'hEF, 8'hF0: is_shared = 1'b1;
            default: is_shared = 1'b0;
        endcase
    endfunction

    // insert one bit into a byte
    function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] i, input logic v);
        logic [7:0] r;
        r = b;
        r[i] = v;
        put_bit = r;
    endfunction

endpackage

/* test/paged_sfr_space_decoder_bench.sv */
// paged_sfr_space_decoder_bench: directed accesses through the core request port.
// assumes: sfr_periph_model stands on the peripheral side; inputs change on the falling edge.
`timescale 1ns/10ps
module paged_sfr_space_decoder_bench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk;
    logic reset;
    sfr_space_pkg::core_req_t req;
    logic req_ready;
    logic done;
    logic [7:0] rdata;
    logic bit_refused;
    logic ram_access;
    logic [7:0] ram_addr;
    sfr_space_pkg::periph_bus_t periph;
    logic [7:0] periph_rdata;
    logic [7:0] page;
    int n_mismatch;
    int n_checks;
    int n_cyc;             // cycles from taken edge to done
    int n_str;             // peripheral strobes seen
    logic [7:0] got_data;  // rdata at done
    logic got_ref;         // bit_refused at done
    logic got_pf;          // page_f at last strobe
    logic got_sh;          // shared at last strobe

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    paged_sfr_space_decoder i_dut (.clk(clk), .reset(reset), .req(req), .req_ready(req_ready), .done(done),
        .rdata(rdata), .bit_refused(bit_refused), .ram_access(ram_access), .ram_addr(ram_addr),
        .periph(periph), .periph_rdata(periph_rdata), .page(page));
    sfr_periph_model i_model (.clk(clk), .periph(periph), .periph_rdata(periph_rdata));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic test_done;
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one access: hold the request over the taken edge, then watch until done
    task automatic xfer(input logic r, input logic w, input logic be, input logic [2:0] bi,
        input logic [7:0] a, input logic [7:0] wd);
        logic got;
        got = 1'b0;
        @(negedge clk);
        req = '{rd: r, wr: w, bit_en: be, bit_idx: bi, bit_val: wd[0], addr: a, wdata: wd};
        @(posedge clk);
        n_cyc = 0;
        n_str = 0;
        got_data = 8'hXX;
        got_ref = 1'bX;
        while (!got && n_cyc < 8)
        begin
            @(negedge clk);
            req.rd = 1'b0;
            req.wr = 1'b0;
            n_cyc++;
            if (periph.rd === 1'b1 || periph.wr === 1'b1)
            begin
                n_str++;
                got_pf = periph.page_f;
                got_sh = periph.shared;
            end
            if (done === 1'b1)
            begin
                got = 1'b1;
                got_data = rdata;
                got_ref = bit_refused;
            end
        end
    endtask

    // byte shorthands
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b0, 1'b1, 1'b0, 3'h0, a, d);
    endtask
    task automatic rd_byte(input logic [7:0] a);
        xfer(1'b1, 1'b0, 1'b0, 3'h0, a, 8'h00);
    endtask

    // data memory access: one-cycle pulse with the address, no done
    task automatic ram_rd(input logic [7:0] a);
        @(negedge clk);
        req = '{rd: 1'b1, wr: 1'b0, bit_en: 1'b0, bit_idx: 3'h0, bit_val: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clk);
        check("ram_access", {7'h00, ram_access}, 8'h01);
        check("ram_addr", ram_addr, a);
        req.rd = 1'b0;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    // watchdog: the whole sequence needs well under 5000 cycles
    initial
    begin
        #(20 * 5000);
        n_mismatch++;
        test_done();
    end

    // main sequence
    initial
    begin
        n_mismatch = 0;
        n_checks = 0;
        req = '0;
        reset = 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        check("page reset", page, 8'h00);
        check("ready", {7'h00, req_ready}, 8'h01);
        // page register reads back zero and never strobes
        rd_byte(8'hA7);
        check("page rd", got_data, 8'h00);
        check("page cycles", 8'(n_cyc), 8'h02);
        check("page strobes", 8'(n_str), 8'h00);
        // same address, two pages, two registers
        wr_byte(8'h8A, 8'h3C);
        check("p0 page_f", {7'h00, got_pf}, 8'h00);
        wr_byte(8'hA7, 8'h0F);
        check("page port", page, 8'h0F);
        rd_byte(8'hA7);
        check("page rd F", got_data, 8'h0F);
        wr_byte(8'h8A, 8'hC3);
        check("pF page_f", {7'h00, got_pf}, 8'h01);
        rd_byte(8'h8A);
        check("pF data", got_data, 8'hC3);
        // shared register written on page F
        wr_byte(8'h90, 8'h5A);
        check("shared flag", {7'h00, got_sh}, 8'h01);
        check("shared page_f", {7'h00, got_pf}, 8'h00);
        wr_byte(8'hA7, 8'h00);
        rd_byte(8'h8A);
        check("p0 data", got_data, 8'h3C);
        rd_byte(8'h90);
        check("shared on p0", got_data, 8'h5A);
        // bit write on column 8 is read-modify-write
        wr_byte(8'h88, 8'h00);
        xfer(1'b0, 1'b1, 1'b1, 3'h3, 8'h88, 8'h01);
        check("bit cycles", 8'(n_cyc), 8'h03);
        check("bit strobes", 8'(n_str), 8'h02);
        rd_byte(8'h88);
        check("bit byte", got_data, 8'h08);
        xfer(1'b1, 1'b0, 1'b1, 3'h3, 8'h88, 8'h00);
        check("bit read", got_data, 8'h01);
        // bit access on other columns is refused
        xfer(1'b0, 1'b1, 1'b1, 3'h1, 8'h89, 8'h01);
        check("refuse cycles", 8'(n_cyc), 8'h01);
        check("refused", {7'h00, got_ref}, 8'h01);
        check("refuse strobes", 8'(n_str), 8'h00);
        xfer(1'b0, 1'b1, 1'b1, 3'h0, 8'hA7, 8'h01);
        check("page bit", {7'h00, got_ref}, 8'h01);
        rd_byte(8'hA7);
        check("page kept", got_data, 8'h00);
        // unnamed page: only shared registers decode
        wr_byte(8'hA7, 8'h03);
        rd_byte(8'h8A);
        check("reserved data", got_data, 8'h00);
        check("reserved strobes", 8'(n_str), 8'h00);
        rd_byte(8'h90);
        check("shared any page", got_data, 8'h5A);
        // boundary: 0x80 is in space, 0x7F and 0x00 go to data memory one idle cycle apart
        wr_byte(8'h80, 8'h11);
        check("0x80 strobes", 8'(n_str), 8'h01);
        ram_rd(8'h7F);
        ram_rd(8'h00);
        // reset in mid-run returns page 0
        wr_byte(8'hA7, 8'h0F);
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        check("page re-reset", page, 8'h00);
        test_done();
    end
endmodule // paged_sfr_space_decoder_bench

/* test/sfr_periph_model.sv */
// sfr_periph_model: behavioural bank of peripheral registers behind the decoder.
// assumes: one register per page/address pair, read data answered in the cycle of the read strobe.
`timescale 1ns/10ps
module sfr_periph_model
(
    // clock
    input wire logic clk,
    // strobe from the decoder
    input wire sfr_space_pkg::periph_bus_t periph,
    // read answer
    output logic [7:0] periph_rdata
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] regs_q [0:255]; // one byte per page half and address
    logic [7:0] idle_q;         // toggling filler while not selected
    logic [7:0] idx;            // register slot

    // upper page gets its own half, shared registers always sit in the lower half
    assign idx = {periph.page_f, periph.addr[6:0]};

    // distinct start values so a wrong slot shows up
    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            regs_q[i] = 8'(i) ^ 8'hA5;
        end
        idle_q = 8'h55;
    end

    // write strobe updates the slot; a bit write arrives as a whole byte
    always @(posedge clk)
    begin
        idle_q <= ~idle_q;
        if (periph.wr)
        begin
            regs_q[idx] <= periph.wdata;
        end
    end

    // answer only while read is strobed, otherwise a changing pattern
    assign periph_rdata = periph.rd ? regs_q[idx] : idle_q;
endmodule // sfr_periph_model
